// ==== tmr_scaler_pkg.sv ====
package tmr_scaler_pkg;
	// ==========================================
	// Configuration field positions
	localparam int unsigned RATIO_LSB = 0;
	localparam int unsigned RATIO_MSB = 2;
	localparam int unsigned ASSIGN_BIT = 3;
	localparam logic [7:0] CONFIG_RESET = 8'hff;
	// ==========================================
	// Scaler and timer widths
	localparam int unsigned SCALER_WIDTH = 8;
	localparam int unsigned TIMER_WIDTH = 8;
	// ==========================================
	// Phase counter: four phases per instruction cycle
	localparam logic [1:0] PHASE_ONE = 2'h0;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [1:0] PHASE_THREE = 2'h2;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	// Sample-to-increment state codes
	typedef enum logic [2:0]
	{
		sync_idle = 3'h1,
		sync_seen = 3'h2,
		sync_bump = 3'h4
	} sync_state_t;
endpackage

// ==== ripple_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Ripple divider: each stage toggles on the fall of the one below
module ripple_scaler
#(
	parameter int unsigned WIDTH = 8
)
(
	input wire logic clk_in,
	input wire logic clear_n,
	output logic [WIDTH-1:0] taps
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_stage
			logic stage_q;
			logic stage_clk;
			if (i == 0)
			begin : g_first
				assign stage_clk = clk_in;
			end
			else
			begin : g_next
				assign stage_clk = taps[i-1];
			end
			// Asynchronous toggle stage, symmetrical output
			always_ff @(negedge stage_clk or negedge clear_n)
			begin
				if (!clear_n)
					stage_q <= 1'b0;
				else
					stage_q <= ~stage_q;
			end
			assign taps[i] = stage_q;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== timer_ext_clock.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Scaler given to watchdog: raw count pin feeds the synchroniser
// - Scaler output sampled during phase two and phase four each cycle
// - Scaler given to timer: asynchronous ripple divider precedes synchroniser
// - Timer increments only after the synchroniser has caught the edge
// - One 8-bit scaler serves timer prescale or watchdog postscale
// - Scaler belongs to exactly one user; the other runs unscaled
// - Assignment bit and 3-bit ratio sit in config bits three to zero
// - Timer writes clear the scaler while it belongs to the timer
// - Watchdog-clear instruction clears the scaler while watchdog owns it
// - Scaler has no read or write path, only clears
module timer_ext_clock
#(
	parameter int unsigned SCALER_WIDTH = tmr_scaler_pkg::SCALER_WIDTH
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ext_count_clock_pin,
	input wire logic count_falling_edge,
	input wire logic [7:0] config_value,
	input wire logic timer_write,
	input wire logic [7:0] timer_write_data,
	input wire logic watchdog_clear_instruction,
	input wire logic watchdog_tick,
	output logic [7:0] timer_count_register,
	output logic timer_overflow,
	output logic watchdog_timeout_tick,
	output logic [1:0] phase
);
	// ==========================================
	// Configuration decode
	logic scaler_assign_select;
	logic [2:0] scale_ratio_field;
	logic [SCALER_WIDTH-1:0] taps;
	logic scaler_clk;
	logic scaler_clear_n;
	logic clear_req;
	logic clear_hold;
	logic scaled;
	logic edge_in;
	logic sample_a;
	logic sample_b;
	logic sample_prev;
	logic sample_phase;
	logic rise_seen;
	logic [SCALER_WIDTH-1:0] wd_taps_prev;
	tmr_scaler_pkg::sync_state_t sync_state;

	function automatic logic pick_tap(input logic [SCALER_WIDTH-1:0] t,
		input logic [2:0] sel, input logic offset);
		logic [3:0] idx;
		idx = {1'b0, sel} + {3'h0, offset};
		if (idx == 4'h0)
			pick_tap = 1'b0;
		else
			pick_tap = t[idx[2:0] - 3'h1 + 3'h0];
	endfunction

	// ==========================================
	// Phase decode used by the synchroniser
	function automatic logic is_sample_phase(input logic [1:0] p);
		is_sample_phase = (p == tmr_scaler_pkg::PHASE_TWO) ||
			(p == tmr_scaler_pkg::PHASE_FOUR);
	endfunction

	function automatic logic is_detect_phase(input logic [1:0] p);
		is_detect_phase = (p == tmr_scaler_pkg::PHASE_ONE) ||
			(p == tmr_scaler_pkg::PHASE_THREE);
	endfunction

	assign scaler_assign_select =
		config_value[tmr_scaler_pkg::ASSIGN_BIT];
	assign scale_ratio_field =
		config_value[tmr_scaler_pkg::RATIO_MSB:tmr_scaler_pkg::RATIO_LSB];

	// ==========================================
	// Scaler input mux: exactly one user feeds it
	assign edge_in = ext_count_clock_pin ^ count_falling_edge;
	assign scaler_clk = scaler_assign_select ? watchdog_tick : edge_in;

	// ==========================================
	// Scaler clear: held for one full clock after a clearing event
	assign clear_req = scaler_assign_select ?
		watchdog_clear_instruction : timer_write;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clear_hold <= 1'b1;
		end
		else
		begin
			clear_hold <= clear_req;
		end
	end
	assign scaler_clear_n = ~clear_hold;

	ripple_scaler
	#(
		.WIDTH(SCALER_WIDTH)
	)
	u_scaler
	(
		.clk_in(scaler_clk),
		.clear_n(scaler_clear_n),
		.taps(taps)
	);

	// ==========================================
	// Count source: ratio 2^(n+1) for timer, raw pin for watchdog owner
	always_comb
	begin
		if (scaler_assign_select)
		begin
			scaled = edge_in;
		end
		else
		begin
			scaled = taps[scale_ratio_field];
		end
	end

	// ==========================================
	// Phase generator
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase <= tmr_scaler_pkg::PHASE_ONE;
		end
		else
		begin
			phase <= phase + 2'h1;
		end
	end

	// ==========================================
	// Synchroniser sampling only at phase two and phase four
	assign sample_phase = is_sample_phase(phase);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_a <= 1'b0;
		end
		else if (sample_phase)
		begin
			sample_a <= scaled;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_b <= 1'b0;
		end
		else if (sample_phase)
		begin
			sample_b <= sample_a;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_prev <= 1'b0;
		end
		else if (sample_phase)
		begin
			sample_prev <= sample_b;
		end
	end

	// ==========================================
	// Edge seen in the cycle right after each sample, so none is lost
	assign rise_seen = sample_b && !sample_prev &&
		is_detect_phase(phase);

	// ==========================================
	// Increment after the captured rising edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_state <= tmr_scaler_pkg::sync_idle;
		end
		else
		begin
			unique case (sync_state)
				tmr_scaler_pkg::sync_idle:
				begin
					if (rise_seen)
					begin
						sync_state <= tmr_scaler_pkg::sync_seen;
					end
				end
				tmr_scaler_pkg::sync_seen:
				begin
					sync_state <= tmr_scaler_pkg::sync_bump;
				end
				tmr_scaler_pkg::sync_bump:
				begin
					sync_state <= tmr_scaler_pkg::sync_idle;
				end
				default:
				begin
					sync_state <= tmr_scaler_pkg::sync_idle;
				end
			endcase
		end
	end

	// ==========================================
	// Timer count register; a write wins over an increment
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_count_register <= 8'h00;
		end
		else if (timer_write)
		begin
			timer_count_register <= timer_write_data;
		end
		else if (sync_state == tmr_scaler_pkg::sync_bump)
		begin
			timer_count_register <= timer_count_register + 8'h01;
		end
	end

	// ==========================================
	// Overflow flag: one cycle on the step from all ones to zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_overflow <= 1'b0;
		end
		else if (timer_write)
		begin
			timer_overflow <= 1'b0;
		end
		else if (sync_state == tmr_scaler_pkg::sync_bump)
		begin
			timer_overflow <= (timer_count_register == 8'hff);
		end
		else
		begin
			timer_overflow <= 1'b0;
		end
	end

	// ==========================================
	// Watchdog postscale output, ratio 2^n (n=0 passes every tick)
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_taps_prev <= '0;
		end
		else
		begin
			wd_taps_prev <= taps;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			watchdog_timeout_tick <= 1'b0;
		end
		else if (!scaler_assign_select)
		begin
			watchdog_timeout_tick <= watchdog_tick;
		end
		else if (scale_ratio_field == 3'h0)
		begin
			watchdog_timeout_tick <= watchdog_tick;
		end
		else if (clear_hold)
		begin
			// Taps dropping on a clear are no timeout
			watchdog_timeout_tick <= 1'b0;
		end
		else
		begin
			watchdog_timeout_tick <=
				pick_tap(wd_taps_prev, scale_ratio_field, 1'b0) &
				~pick_tap(taps, scale_ratio_field, 1'b0);
		end
	end
endmodule
`default_nettype wire

// ==== tec_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module tec_chk
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ext_count_clock_pin,
	input wire logic count_falling_edge,
	input wire logic [7:0] config_value,
	input wire logic timer_write,
	input wire logic [7:0] timer_write_data,
	input wire logic [7:0] timer_count_register,
	input wire logic timer_overflow,
	input wire logic [1:0] phase
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	wire logic [9:0] cur = {ext_count_clock_pin, count_falling_edge,
		config_value};
	logic [9:0] last;
	logic [3:0] quiet;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last <= 10'h000;
			quiet <= 4'h0;
		end
		else
		begin
			last <= cur;
			if (timer_write || cur != last)
				quiet <= 4'h0;
			else if (quiet != 4'hf)
				quiet <= quiet + 4'h1;
		end
	end
	phase_fwd_a: assert property (phase == 2'h1 |=>
		phase == 2'h2 ##1 phase == 2'h3) else $error("phase order");
	phase_wrap_a: assert property (phase == 2'h3 |=>
		phase == 2'h0 ##1 phase == 2'h1) else $error("phase wrap");
	write_load_a: assert property (timer_write |=>
		timer_count_register == $past(timer_write_data)) else $error("load");
	count_step_a: assert property (!$past(timer_write) &&
		$changed(timer_count_register) |-> timer_count_register ==
		$past(timer_count_register) + 8'h1) else $error("count step");
	step_gap_a: assert property (!$past(timer_write) && !timer_write &&
		timer_count_register == $past(timer_count_register) + 8'h1 |=>
		$stable(timer_count_register)) else $error("double step");
	ovf_zero_a: assert property (timer_overflow |->
		timer_count_register == 8'h00) else $error("overflow value");
	ovf_pulse_a: assert property (timer_overflow |=>
		!timer_overflow) else $error("overflow width");
	pin_quiet_a: assert property (quiet > 4'h9 |->
		$stable(timer_count_register)) else $error("count without edge");
endmodule
bind timer_ext_clock tec_chk i_tec_chk (.sys_clk, .rst_n,
	.ext_count_clock_pin, .count_falling_edge, .config_value, .timer_write,
	.timer_write_data, .timer_count_register, .timer_overflow, .phase);
`default_nettype wire

// ==== clk_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Count clock source, idle low between bursts
module clk_src
(
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [9:0] pulses,
	input wire logic [3:0] half,
	output logic pin = 1'b0,
	output logic busy = 1'b0
);
	always @(posedge sys_clk)
	begin
		if (go)
		begin
			busy <= 1'b1;
			repeat (pulses)
			begin
				repeat (half) @(posedge sys_clk);
				pin <= 1'b1;
				repeat (half) @(posedge sys_clk);
				pin <= 1'b0;
			end
			busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== tb_timer_ext_clock.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb_timer_ext_clock;
	logic sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, count_falling_edge = 1'b0;
	logic timer_write = 1'b0, watchdog_clear_instruction = 1'b0;
	logic watchdog_tick = 1'b0, pin, busy, ovf, wdt;
	logic [7:0] config_value = 8'h08, timer_write_data = 8'h00, cnt;
	logic [9:0] pulses = 10'h000;
	logic [3:0] half = 4'h2;
	int fail_count = 0, tests_run = 0, cycles = 0, wd_ticks = 0;
	clk_src i_clk_src (.sys_clk, .go, .pulses, .half, .pin, .busy);
	timer_ext_clock i_timer_ext_clock (.sys_clk, .rst_n,
		.ext_count_clock_pin(pin), .count_falling_edge, .config_value,
		.timer_write, .timer_write_data, .watchdog_clear_instruction,
		.watchdog_tick, .timer_count_register(cnt), .timer_overflow(ovf),
		.watchdog_timeout_tick(wdt), .phase());
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		wd_ticks <= wd_ticks + int'(wdt === 1'b1);
	end
	task automatic close_out;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk);
		timer_write <= 1'b1;
		timer_write_data <= d;
		@(posedge sys_clk);
		timer_write <= 1'b0;
	endtask
	task automatic send(input logic [9:0] n, input logic [3:0] h);
		@(posedge sys_clk);
		pulses <= n;
		half <= h;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 4000 && busy; i++)
			@(posedge sys_clk);
		repeat (12) @(posedge sys_clk);
	endtask
	task automatic wd(input int n, input logic c);
		repeat (n)
		begin
			@(posedge sys_clk);
			watchdog_tick <= 1'b1;
			@(posedge sys_clk);
			watchdog_tick <= 1'b0;
		end
		watchdog_clear_instruction <= c;
		@(posedge sys_clk);
		watchdog_clear_instruction <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic t_unscaled;
		for (int e = 0; e < 2; e++)
		begin
			count_falling_edge <= e[0];
			repeat (12) @(posedge sys_clk);
			wr(8'h00);
			send(10'h005, 4'h3);
			check(cnt, 8'h05);
		end
		count_falling_edge <= 1'b0;
		wr(8'hfe);
		send(10'h002, 4'h2);
		check(cnt, 8'h00);
		$display("unscaled done");
	endtask
	task automatic t_scaled;
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h00);
			config_value <= {5'h00, k[2:0]};
			send(10'(3 << (k + 1)), 4'h2);
			check(cnt, 8'h03);
		end
		wr(8'h00);
		config_value <= 8'h01;
		send(10'h003, 4'h2);
		check(cnt, 8'h01);
		wr(8'h00);
		send(10'h002, 4'h2);
		check(cnt, 8'h01);
		send(10'h004, 4'h2);
		check(cnt, 8'h02);
		$display("scaled done");
	endtask
	task automatic t_wd;
		int base;
		config_value <= 8'h0a;
		wd(0, 1'b1);
		base = wd_ticks;
		wd(3, 1'b1);
		wd(3, 1'b0);
		check(8'(wd_ticks - base), 8'h00);
		wd(1, 1'b0);
		check(8'(wd_ticks - base), 8'h01);
		wd(3, 1'b0);
		wr(8'h00);
		wd(1, 1'b0);
		check(8'(wd_ticks - base), 8'h02);
		$display("watchdog done");
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_unscaled();
		t_scaled();
		t_wd();
		close_out();
	end
	initial
	begin
		wait (cycles == 20000);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
